// *** nfb_pkg.sv ***
/*
  Package for the NOR flash bus host controller: bus phase timing,
  page geometry and block map constants.
  Assumes a 125 MHz core clock driving the flash pins directly.
*/
package nfb_pkg;
  // Core clock period in picoseconds
  localparam int CLK_PS = 8000;
  // Bus phase times in nanoseconds
  localparam int T_SETUP_NS = 10;
  localparam int T_PULSE_NS = 40;
  localparam int T_HOLD_NS = 10;
  localparam int T_ACC_NS = 70;
  localparam int T_PAGE_NS = 25;
  localparam int T_RST_NS = 500;
  // Least times round up
  localparam int SETUP_CYC = (T_SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int PULSE_CYC = (T_PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int HOLD_CYC = (T_HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int ACC_CYC = (T_ACC_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int PAGE_CYC = (T_PAGE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RST_CYC = (T_RST_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CNT_W = 8;
  // Page of eight words, word picked by the low three address bits
  localparam int PAGE_WORDS = 8;
  localparam int PAGE_LSB_W = 3;
  // Block map: boot and main block sizes in words
  localparam int BOOT_BLK_KW_LSB = 12; // 4 kilo_words
  localparam int MAIN64_KW_LSB = 15;   // 32 kilo_words
  localparam int MAIN128_KW_LSB = 16;  // 64 kilo_words
  localparam int BOOT_BLKS = 8;
  localparam int MAIN_BLKS_64 = 127;
  localparam int TOP_BOOT_FIRST = 127;
  localparam int IDX_W = 8;
  // Variant codes
  localparam logic [1:0] VAR_UNIFORM64 = 2'h0;
  localparam logic [1:0] VAR_TOP64 = 2'h1;
  localparam logic [1:0] VAR_BOT64 = 2'h2;
  localparam logic [1:0] VAR_UNIFORM128 = 2'h3;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_SETUP = 6'b000010,
    ST_PULSE = 6'b000100,
    ST_HOLD = 6'b001000,
    ST_PAGE = 6'b010000,
    ST_RESET = 6'b100000
  } nfb_state_e;
endpackage : nfb_pkg

// *** nfb_host.sv ***
/*
  Host side bus controller for a parallel NOR flash. Runs random and
  page reads, command writes and hardware reset pulses on the pins.
  Assumes the data bus resolves from DQ_O/DQ_OE in the surroundings
  and that the flash is wired with the same width strap as BYTE_MODE.
*/
`timescale 1ns/1ps
module nfb_host
  import nfb_pkg::*;
#(
  parameter int ADDR_W = 23
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic REQ_RESET,
  input wire logic REQ_NO_PAGE,
  input wire logic [ADDR_W-1:0] REQ_ADDR,
  input wire logic [15:0] REQ_WDATA,
  input wire logic BYTE_MODE,
  input wire logic WP_PROTECT,
  input wire logic [1:0] VARIANT,
  input wire logic [15:0] DQ_I,
  output logic REQ_READY,
  output logic RSP_VALID,
  output logic [15:0] RSP_RDATA,
  output logic [nfb_pkg::IDX_W-1:0] RSP_BLOCK,
  output logic [ADDR_W-1:0] FL_ADDR,
  output logic FL_CE_N,
  output logic FL_OE_N,
  output logic FL_WE_N,
  output logic FL_RST_N,
  output logic FL_WP_N,
  output logic [15:0] DQ_O,
  output logic [15:0] DQ_OE
);
  import nfb_pkg::*;

  // Refuse address widths the block map and page logic cannot serve
  if (ADDR_W < 16 || ADDR_W > 24) begin : g_bad_addr_w
    $error("nfb_host: ADDR_W out of range");
  end

  nfb_state_e state_r;
  logic [CNT_W-1:0] cnt_r;
  logic wr_r;
  logic page_ok_r;
  logic no_page_r; // Request kind kept, input may move during the read
  logic [ADDR_W-1:0] page_base_r;
  logic [15:0] dq_s1_r;
  logic [15:0] dq_s2_r;
  logic [IDX_W-1:0] blk_nxt;
  logic [ADDR_W-1:0] wa;

  ////////////////////////////////////////////////////////////////////
  // Word address of request: byte mode drops the byte lsb
  assign wa = BYTE_MODE ? (REQ_ADDR >> 1) : REQ_ADDR;

  // boot map x8, boot map x16
  always_comb begin
    blk_nxt = '0;
    case (VARIANT)
      VAR_UNIFORM64: blk_nxt = IDX_W'(wa >> MAIN64_KW_LSB);
      VAR_UNIFORM128: blk_nxt = IDX_W'(wa >> MAIN128_KW_LSB);
      VAR_TOP64: begin
        if ((wa >> MAIN64_KW_LSB) < MAIN_BLKS_64) begin
          blk_nxt = IDX_W'(wa >> MAIN64_KW_LSB);
        end else begin
          blk_nxt = IDX_W'(TOP_BOOT_FIRST) +
                    IDX_W'((wa >> BOOT_BLK_KW_LSB) & (BOOT_BLKS - 1));
        end
      end
      VAR_BOT64: begin
        if ((wa >> MAIN64_KW_LSB) == 0) begin
          blk_nxt = IDX_W'(wa >> BOOT_BLK_KW_LSB);
        end else begin
          blk_nxt = IDX_W'(wa >> MAIN64_KW_LSB) + IDX_W'(BOOT_BLKS - 1);
        end
      end
      default: blk_nxt = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Data pin synchroniser, pins are outside the clock domain
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      dq_s1_r <= 16'h0000;
      dq_s2_r <= 16'h0000;
    end else if (CLK_EN) begin
      dq_s1_r <= DQ_I;
      dq_s2_r <= dq_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bus sequencer. Strobes are held many cycles, far above any glitch
  // filter, so no edge the host makes can be mistaken for noise.
  // strobe widths
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      wr_r <= 1'b0;
      page_ok_r <= 1'b0;
      no_page_r <= 1'b0;
      page_base_r <= '0;
      REQ_READY <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_RDATA <= 16'h0000;
      RSP_BLOCK <= '0;
      FL_ADDR <= '0;
      FL_CE_N <= 1'b1;
      FL_OE_N <= 1'b1;
      FL_WE_N <= 1'b1;
      FL_RST_N <= 1'b1;
      FL_WP_N <= 1'b1;
      DQ_O <= 16'h0000;
      DQ_OE <= 16'h0000;
    end else if (CLK_EN) begin
      RSP_VALID <= 1'b0;
      FL_WP_N <= ~WP_PROTECT;
      case (state_r)
        ST_IDLE: begin
          REQ_READY <= 1'b1;
          if (REQ_VALID && REQ_READY) begin
            REQ_READY <= 1'b0;
            RSP_BLOCK <= blk_nxt;
            if (REQ_RESET) begin
              FL_RST_N <= 1'b0;
              FL_CE_N <= 1'b1;
              FL_OE_N <= 1'b1;
              page_ok_r <= 1'b0;
              cnt_r <= CNT_W'(RST_CYC);
              state_r <= ST_RESET;
            // Page spans A2..A0, plus the byte lsb in byte mode
            end else if (!REQ_WRITE && page_ok_r && !REQ_NO_PAGE &&
                         (BYTE_MODE ?
                          (REQ_ADDR >> (PAGE_LSB_W + 1)) ==
                          (page_base_r >> (PAGE_LSB_W + 1)) :
                          (REQ_ADDR >> PAGE_LSB_W) ==
                          (page_base_r >> PAGE_LSB_W))) begin
              // page hit, only low address bits move
              FL_ADDR <= BYTE_MODE ? (REQ_ADDR >> 1) : REQ_ADDR;
              DQ_O[15] <= REQ_ADDR[0];
              cnt_r <= CNT_W'(PAGE_CYC + 2);
              state_r <= ST_PAGE;
            end else begin
              // a new access selects the chip; after a read it is still selected
              wr_r <= REQ_WRITE;
              no_page_r <= REQ_NO_PAGE;
              page_base_r <= REQ_ADDR;
              FL_ADDR <= BYTE_MODE ? (REQ_ADDR >> 1) : REQ_ADDR;
              FL_CE_N <= 1'b0;
              // byte mode reads: DQ15 carries byte lsb address; writes drive REQ_WDATA[15] there
              DQ_O <= REQ_WRITE ? REQ_WDATA :
                      {REQ_ADDR[0], 15'h0000};
              DQ_OE <= REQ_WRITE ? (BYTE_MODE ? 16'h80FF : 16'hFFFF) :
                       (BYTE_MODE ? 16'h8000 : 16'h0000);
              cnt_r <= CNT_W'(SETUP_CYC);
              state_r <= ST_SETUP;
            end
          end
        end
        ST_SETUP: begin
          if (cnt_r > 1) begin
            cnt_r <= cnt_r - 1'b1;
          end else if (wr_r) begin
            // address stable before later falling edge
            FL_WE_N <= 1'b0;
            cnt_r <= CNT_W'(PULSE_CYC);
            state_r <= ST_PULSE;
          end else begin
            // device drives only while output enable low
            FL_OE_N <= 1'b0;
            cnt_r <= CNT_W'(ACC_CYC + 2);
            state_r <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          if (cnt_r > 1) begin
            cnt_r <= cnt_r - 1'b1;
          end else begin
            // data held past earlier rising edge
            // data valid across the whole write
            FL_WE_N <= 1'b1;
            if (!wr_r) begin
              // data from whatever space the mode selects
              RSP_RDATA <= BYTE_MODE ? {8'h00, dq_s2_r[7:0]} : dq_s2_r;
              RSP_VALID <= 1'b1;
              // paging off for query or extended space
              page_ok_r <= ~no_page_r;
              REQ_READY <= 1'b1;
              state_r <= ST_IDLE;
            end else begin
              page_ok_r <= 1'b0;
              cnt_r <= CNT_W'(HOLD_CYC);
              state_r <= ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          if (cnt_r > 1) begin
            cnt_r <= cnt_r - 1'b1;
          end else begin
            // busy flash keeps working once deselected
            FL_CE_N <= 1'b1;
            DQ_OE <= 16'h0000;
            state_r <= ST_IDLE;
          end
        end
        ST_PAGE: begin
          if (cnt_r > 1) begin
            cnt_r <= cnt_r - 1'b1;
          end else begin
            RSP_RDATA <= BYTE_MODE ? {8'h00, dq_s2_r[7:0]} : dq_s2_r;
            RSP_VALID <= 1'b1;
            REQ_READY <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        ST_RESET: begin
          if (cnt_r > 1) begin
            cnt_r <= cnt_r - 1'b1;
          end else begin
            FL_RST_N <= 1'b1;
            DQ_OE <= 16'h0000;
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
      // Leaving a read: raise output enable only, chip enable stays low, when a write follows or paging is off
      if (state_r == ST_IDLE && REQ_VALID && REQ_READY && !REQ_RESET &&
          FL_OE_N == 1'b0 && (REQ_WRITE || !page_ok_r)) begin
        FL_OE_N <= 1'b1;
      end
    end
  end
endmodule : nfb_host

// *** nfb_checker.sv ***
/*
  Pin checker for the NOR flash host controller.
  Assumes a bind from the bench and CLK_EN held high.
*/
`timescale 1ns/1ps
module nfb_checker #(
  parameter int ADDR_W = 23
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic BYTE_MODE,
  input wire logic FL_CE_N,
  input wire logic FL_OE_N,
  input wire logic FL_WE_N,
  input wire logic FL_RST_N,
  input wire logic [ADDR_W-1:0] FL_ADDR,
  input wire logic [15:0] DQ_O,
  input wire logic [15:0] DQ_OE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////
  // Write strobe five cycles, address and data held meanwhile
  sequence s_we_low;
    !FL_WE_N [*5] ##1 FL_WE_N;
  endsequence
  sequence s_we_hold;
    ($stable(FL_ADDR) && $stable(DQ_O) && DQ_OE[7:0] == 8'hFF) [*5];
  endsequence
  property p_we_width;
    $fell(FL_WE_N) |-> s_we_low;
  endproperty
  a_we_width: assert property (p_we_width)
    else $error("write strobe width wrong");
  property p_we_hold;
    $fell(FL_WE_N) |-> s_we_hold;
  endproperty
  a_we_hold: assert property (p_we_hold)
    else $error("write address or data moved");
  property p_wr_sel;
    !FL_WE_N |-> !FL_CE_N && FL_RST_N;
  endproperty
  a_wr_sel: assert property (p_wr_sel)
    else $error("write without select");
  // Host drive of DQ7..DQ0 never overlaps a device read
  property p_wr_oe;
    (DQ_OE[7:0] != 8'h00) |-> FL_OE_N;
  endproperty
  a_wr_oe: assert property (p_wr_oe)
    else $error("output enable low while driving");
  property p_rd_sel;
    !FL_OE_N |-> !FL_CE_N && FL_WE_N && FL_RST_N;
  endproperty
  a_rd_sel: assert property (p_rd_sel)
    else $error("read strobes wrong");
  property p_byte_hi;
    BYTE_MODE |-> DQ_OE[14:8] == 7'h00;
  endproperty
  a_byte_hi: assert property (p_byte_hi)
    else $error("upper data driven in byte mode");
  property p_byte_lsb;
    BYTE_MODE && !FL_OE_N |-> DQ_OE[15];
  endproperty
  a_byte_lsb: assert property (p_byte_lsb)
    else $error("byte lsb address not driven");
  property p_rst_nowr;
    !FL_RST_N |-> FL_WE_N;
  endproperty
  a_rst_nowr: assert property (p_rst_nowr)
    else $error("write during flash reset");
endmodule : nfb_checker

// *** nfb_flash_model.sv ***
/*
  Behavioural flash device: fixed array pattern, command latch.
  Assumes no clock; floating pins show the inverted word.
*/
`timescale 1ns/1ps
module nfb_flash_model (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic rst_n,
  input wire logic byte_mode,
  input wire logic [22:0] addr,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out
);
  logic [15:0] word;
  logic [22:0] cmd_addr = 23'h000000;
  logic [15:0] cmd_data = 16'h0000;
  logic wr_act = 1'b0;
  logic oe_err = 1'b0;
  assign word = addr[15:0] ^ 16'hA5C3;
  ////////////////////////////////////////
  // array read out
  always_comb begin
    dq_out = ~word;
    if (!ce_n && !oe_n && we_n && rst_n) begin
      dq_out[7:0] = byte_mode && dq_in[15] ? word[15:8] : word[7:0];
      if (!byte_mode) dq_out[15:8] = word[15:8];
    end
  end
  always @(negedge ce_n or negedge we_n)
    if (!ce_n && !we_n && rst_n) begin
      cmd_addr <= addr;
      wr_act <= 1'b1;
    end
  always @(posedge ce_n or posedge we_n)
    if (wr_act) begin
      cmd_data <= dq_in;
      wr_act <= 1'b0;
    end
  always @(negedge oe_n)
    if (wr_act) oe_err <= 1'b1;
endmodule : nfb_flash_model

// *** test_nor_flash_bus_interface.sv ***
/*
  Bench for the NOR flash host controller against the device model.
  Assumes CLK_EN high outside the freeze test; inputs change on the
  falling edge.
*/
`timescale 1ns/1ps
module test_nor_flash_bus_interface;
  import nfb_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, valid = 1'b0, wr = 1'b0, rs = 1'b0;
  logic np = 1'b0, byte_m = 1'b0, wp = 1'b0, en = 1'b1;
  logic [1:0] variant = 2'h0;
  logic [22:0] addr = 23'h000000;
  logic [15:0] wdata = 16'h0000;
  logic ready, rsp_v, ce_n, oe_n, we_n, frst_n, wp_n;
  logic [15:0] rdata, dq_o, dq_oe, dq_i, m_out;
  logic [7:0] blk;
  logic [22:0] fl_addr;
  int failures = 0, compares = 0, rst_lo = 0;
  nfb_host DUT (.CORE_CLK(clk), .RST_N(rst_n), .CLK_EN(en),
    .REQ_VALID(valid), .REQ_WRITE(wr), .REQ_RESET(rs), .REQ_NO_PAGE(np),
    .REQ_ADDR(addr), .REQ_WDATA(wdata), .BYTE_MODE(byte_m),
    .WP_PROTECT(wp), .VARIANT(variant), .DQ_I(dq_i), .REQ_READY(ready),
    .RSP_VALID(rsp_v), .RSP_RDATA(rdata), .RSP_BLOCK(blk),
    .FL_ADDR(fl_addr), .FL_CE_N(ce_n), .FL_OE_N(oe_n), .FL_WE_N(we_n),
    .FL_RST_N(frst_n), .FL_WP_N(wp_n), .DQ_O(dq_o), .DQ_OE(dq_oe));
  nfb_flash_model u_flash (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .rst_n(frst_n), .byte_mode(byte_m), .addr(fl_addr), .dq_in(dq_i),
    .dq_out(m_out));
  // Wire level: host bits where enabled, device elsewhere
  assign dq_i = (dq_oe & dq_o) | (~dq_oe & m_out);
  // Sampled off the launching edge to avoid a race with the design
  always @(negedge clk) if (!frst_n) rst_lo++;
  ////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One request, then wait for the response or ready again
  task automatic run(input logic w, input logic r, input logic [22:0] a,
                     output int n);
    @(negedge clk);
    {wr, rs, addr, wdata, valid} = {w, r, a, 16'h00AA, 1'b1};
    n = 0;
    while (ready !== 1'b1 && n < 200) begin @(negedge clk); n++; end
    @(negedge clk);
    valid = 1'b0;
    n = 1;
    while (((w | r) ? ready : rsp_v) !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check("handshake", {15'h0, n < 200}, 16'h0001);
  endtask : run
  task automatic t_map;
    logic [1:0] v[6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
    logic [22:0] a[6] = '{23'h3F8000, 23'h3FF000, 23'h3F7FFF,
                          23'h007000, 23'h008000, 23'h7F0000};
    logic [7:0] b[6] = '{8'h7F, 8'h86, 8'h7E, 8'h07, 8'h08, 8'h7F};
    int n;
    for (int i = 0; i < 6; i++) begin
      variant = v[i];
      run(1'b0, 1'b0, a[i], n);
      check("block", {8'h00, blk}, {8'h00, b[i]});
      check("rdata", rdata, a[i][15:0] ^ 16'hA5C3);
    end
    $display("map test done");
  endtask : t_map
  task automatic t_page;
    int n;
    run(1'b0, 1'b0, 23'h001230, n);
    run(1'b0, 1'b0, 23'h001235, n);
    check("page_fast", {15'h0, n < 10}, 16'h0001);
    check("page_data", rdata, 16'h1235 ^ 16'hA5C3);
    run(1'b0, 1'b0, 23'h001238, n);
    check("page_edge", {15'h0, n >= 10}, 16'h0001);
    check("edge_data", rdata, 16'h1238 ^ 16'hA5C3);
    np = 1'b1;
    run(1'b0, 1'b0, 23'h001239, n);
    np = 1'b0;
    check("no_page", {15'h0, n >= 10}, 16'h0001);
    run(1'b0, 1'b0, 23'h00123A, n);
    check("after_query", {15'h0, n >= 10}, 16'h0001);
    $display("page test done");
  endtask : t_page
  task automatic t_write;
    int n;
    run(1'b1, 1'b0, 23'h000555, n);
    check("cmd_addr", u_flash.cmd_addr[15:0], 16'h0555);
    check("cmd_data", u_flash.cmd_data, 16'h00AA);
    check("oe_err", {15'h0, u_flash.oe_err}, 16'h0000);
    $display("write test done");
  endtask : t_write
  // Clock enable low: a pending write must not start
  task automatic t_freeze;
    int n;
    @(negedge clk);
    en = 1'b0;
    {wr, rs, addr, wdata, valid} = {1'b1, 1'b0, 23'h0002AA, 16'h00AA, 1'b1};
    repeat (4) @(negedge clk);
    check("freeze_ce", {15'h0, ce_n}, 16'h0001);
    check("freeze_we", {15'h0, we_n}, 16'h0001);
    valid = 1'b0;
    en = 1'b1;
    run(1'b1, 1'b0, 23'h0002AA, n);
    check("freeze_wr", u_flash.cmd_addr[15:0], 16'h02AA);
    $display("freeze test done");
  endtask : t_freeze
  task automatic t_byte;
    int n;
    byte_m = 1'b1;
    run(1'b0, 1'b0, 23'h002469, n);
    check("byte_odd", rdata, {8'h00, 8'h12 ^ 8'hA5});
    run(1'b0, 1'b0, 23'h002468, n);
    check("byte_even", rdata, {8'h00, 8'h34 ^ 8'hC3});
    byte_m = 1'b0;
    $display("byte test done");
  endtask : t_byte
  task automatic t_reset;
    int n;
    wp = 1'b1;
    run(1'b0, 1'b1, 23'h000000, n);
    check("wp_n", {15'h0, wp_n}, 16'h0000);
    check("rst_len", {15'h0, rst_lo == RST_CYC}, 16'h0001);
    wp = 1'b0;
    $display("reset test done");
  endtask : t_reset
  task automatic tally_and_finish;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_map();
    t_page();
    t_write();
    t_freeze();
    t_byte();
    t_reset();
    tally_and_finish();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #50000;
    failures++;
    tally_and_finish();
  end
endmodule : test_nor_flash_bus_interface
bind nfb_host nfb_checker #(.ADDR_W(ADDR_W)) u_chk (.CORE_CLK(CORE_CLK),
  .RST_N(RST_N), .BYTE_MODE(BYTE_MODE), .FL_CE_N(FL_CE_N),
  .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N), .FL_RST_N(FL_RST_N),
  .FL_ADDR(FL_ADDR), .DQ_O(DQ_O), .DQ_OE(DQ_OE));
